// ===== hw/aiss_card_end.sv
// aiss_card_end: card control logic behind the four-location window
// assumes a converter that pulses adcDone with adcData when finished,
// and strap inputs diffMode and codeSel held steady after setup
//
// Function
// - card occupies exactly four mapped locations
// - 32 single-ended or 16 differential channels
// - channel byte write selects that channel directly
// - auto advance steps channel per accepted convert
// - auto advance off until software enables it
// - direct writes mix freely with auto advance
// - convert puts sample-hold into hold in the same cycle as adcStart
// - delay convert until input settled after change
// - extended delay setting lengthens settling hold-off
// - per-channel gain of 1, 2, 4, 8
// - 12-bit result readable at data location
// - result coding chosen by setup option
// - software enables interrupt, scan, external trigger
// - next channel settles during current conversion
`timescale 1ns/1ns
module aiss_card_end (
  input  wire logic                        clk,
  input  wire logic                        rst,
  aiss_bus_if.dev                          bus,
  input  wire logic                        extTrig,
  input  wire logic                        diffMode,
  input  wire logic [1:0]                  codeSel,
  input  wire logic                        adcDone,
  input  wire logic [aiss_pkg::RES_W-1:0]  adcData,
  output logic                             adcStart,
  output logic                             sampleHold,
  output logic [aiss_pkg::CHAN_W-1:0]      selAddr,
  output logic                             selEnable,
  output logic [aiss_pkg::GAIN_W-1:0]      ampGain
);

  typedef struct packed {
    aiss_pkg::aiss_conv_t                           state;
    logic [aiss_pkg::CHAN_W-1:0]                    chan;
    logic [aiss_pkg::CHAN_W-1:0]                    selA;
    logic                                           selEn;
    logic [aiss_pkg::N_CHAN-1:0][aiss_pkg::GAIN_W-1:0] gainTab;
    logic [aiss_pkg::GAIN_W-1:0]                    gain;
    logic [aiss_pkg::CNT_W-1:0]                     settle;
    logic                                           irqEn;
    logic                                           scanEn;
    logic                                           trigEn;
    logic                                           extDly;
    logic                                           convPend;
    logic                                           hold;
    logic                                           start;
    logic [aiss_pkg::RES_W-1:0]                     result;
    logic                                           done;
    logic                                           irq;
    logic [aiss_pkg::DATA_W-1:0]                    rdat;
    logic                                           ack;
  } aiss_card_t;

  aiss_card_t st_ff;
  aiss_card_t nxt_st;

  // settling count for a gain and delay setting
  function automatic logic [aiss_pkg::CNT_W-1:0] settleLoad(
    input logic [aiss_pkg::GAIN_W-1:0] g,
    input logic                        ext
  );
    if (ext)
      settleLoad = aiss_pkg::CNT_W'(aiss_pkg::SETTLE_EXT_CYC);
    else if (g == aiss_pkg::GAIN_X8)
      settleLoad = aiss_pkg::CNT_W'(aiss_pkg::SETTLE_GMAX_CYC);
    else
      settleLoad = aiss_pkg::CNT_W'(aiss_pkg::SETTLE_G1_CYC);
  endfunction : settleLoad

  // next channel in scan order, wrapping at the mode's channel count
  function automatic logic [aiss_pkg::CHAN_W-1:0] nextChan(
    input logic [aiss_pkg::CHAN_W-1:0] c,
    input logic                        diff
  );
    logic [aiss_pkg::CHAN_W-1:0] n;
    n = c + aiss_pkg::CHAN_W'(1);
    if (diff)
      n[aiss_pkg::CHAN_W-1] = 1'b0;
    nextChan = n;
  endfunction : nextChan

  logic                          chanWr;
  logic                          gainWr;
  logic                          ctrlWr;
  logic                          dataRd;
  logic                          convCmd;
  logic                          advance;
  logic [aiss_pkg::CHAN_W-1:0]   wrChan;
  logic [aiss_pkg::CHAN_W-1:0]   newChan;
  logic                          chanChg;
  logic [aiss_pkg::GAIN_W-1:0]   newGain;
  logic [aiss_pkg::DATA_W-1:0]   status;
  logic [aiss_pkg::RES_W-1:0]    coded;

  // address decode of the window
  // four location decode
  assign ctrlWr = bus.wrStb && (bus.addr == aiss_pkg::LOC_CTRL);
  assign chanWr = bus.wrStb && (bus.addr == aiss_pkg::LOC_CHAN);
  assign gainWr = bus.wrStb && (bus.addr == aiss_pkg::LOC_GAIN);
  assign dataRd = bus.rdStb && (bus.addr == aiss_pkg::LOC_DATA);

  // convert request from software or enabled trigger
  // external trigger gate
  assign convCmd = (ctrlWr && bus.wrData[aiss_pkg::CB_CONV]) ||
                   (st_ff.trigEn && extTrig);

  // channel field masked in differential mode
  assign wrChan = diffMode ?
                  {1'b0, bus.wrData[aiss_pkg::CHAN_W-2:0]} :
                  bus.wrData[aiss_pkg::CHAN_W-1:0];

  // channel target: a direct write overrides the scan step
  // step only when scanning enabled
  assign advance = st_ff.start && st_ff.scanEn;
  assign newChan = chanWr ? wrChan :
                   (advance ? nextChan(st_ff.chan, diffMode) : st_ff.chan);
  assign chanChg = chanWr || advance;
  assign newGain = (gainWr && !chanChg) ?
                   bus.wrData[aiss_pkg::GAIN_W-1:0] :
                   st_ff.gainTab[newChan];

  // status word and coded result
  assign status = aiss_pkg::DATA_W'({
                    (st_ff.settle != '0),
                    (st_ff.state == aiss_pkg::AISS_CONV),
                    st_ff.done, st_ff.extDly, st_ff.trigEn,
                    st_ff.scanEn, st_ff.irqEn, 1'b0});
  assign coded = (codeSel == aiss_pkg::CODE_TWOS) ?
                 (adcData ^ aiss_pkg::SIGN_FLIP) : adcData;

  // next-state logic
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.start = 1'b0;
    nxt_st.ack   = bus.rdStb;
    // register writes
    if (ctrlWr)
    begin
      nxt_st.irqEn  = bus.wrData[aiss_pkg::CB_IRQEN];
      nxt_st.scanEn = bus.wrData[aiss_pkg::CB_SCAN];
      nxt_st.trigEn = bus.wrData[aiss_pkg::CB_TRIG];
      nxt_st.extDly = bus.wrData[aiss_pkg::CB_EXTDLY];
    end
    if (gainWr && !chanChg)
      nxt_st.gainTab[st_ff.chan] = bus.wrData[aiss_pkg::GAIN_W-1:0];
    nxt_st.chan = newChan;
    nxt_st.gain = newGain;
    // settling counter runs independently of conversion
    // settle overlaps conversion
    if (st_ff.settle != '0)
      nxt_st.settle = st_ff.settle - aiss_pkg::CNT_W'(1);
    // selector switching
    if (chanChg || !st_ff.selEn)
    begin
      nxt_st.selEn = !chanChg;
      nxt_st.selA  = newChan;
    end
    if (chanChg || (gainWr && newGain != st_ff.gain))
      nxt_st.settle = settleLoad(newGain, ctrlWr ?
                        bus.wrData[aiss_pkg::CB_EXTDLY] : st_ff.extDly);
    if (convCmd)
      nxt_st.convPend = 1'b1;
    // conversion sequencing
    case (st_ff.state)
      aiss_pkg::AISS_IDLE:
      begin
        if (st_ff.convPend && st_ff.settle == '0 && st_ff.selEn &&
            !chanChg)
        begin
          nxt_st.hold     = 1'b1;
          nxt_st.start    = 1'b1;
          nxt_st.convPend = convCmd;
          nxt_st.state    = aiss_pkg::AISS_CONV;
        end
      end
      aiss_pkg::AISS_CONV:
      begin
        if (adcDone)
        begin
          nxt_st.result = coded;
          nxt_st.hold   = 1'b0;
          nxt_st.state  = aiss_pkg::AISS_IDLE;
        end
      end
      default:
      begin
        nxt_st.state = aiss_pkg::AISS_IDLE;
        nxt_st.hold  = 1'b0;
      end
    endcase
    // done flag: set on completion wins over clear by data read
    // readable done flag
    if (st_ff.state == aiss_pkg::AISS_CONV && adcDone)
      nxt_st.done = 1'b1;
    else if (dataRd)
      nxt_st.done = 1'b0;
    nxt_st.irq = nxt_st.done && nxt_st.irqEn;
    // read data path, one cycle after the strobe
    case (bus.addr)
      aiss_pkg::LOC_CTRL: nxt_st.rdat = status;
      aiss_pkg::LOC_CHAN: nxt_st.rdat = aiss_pkg::DATA_W'(st_ff.chan);
      aiss_pkg::LOC_GAIN: nxt_st.rdat = aiss_pkg::DATA_W'(st_ff.gain);
      aiss_pkg::LOC_DATA: nxt_st.rdat = aiss_pkg::DATA_W'(st_ff.result);
      default:            nxt_st.rdat = '0;
    endcase
    if (!bus.rdStb)
      nxt_st.rdat = st_ff.rdat;
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign bus.rdData = st_ff.rdat;
  assign bus.rdAck  = st_ff.ack;
  assign bus.irq    = st_ff.irq;
  assign adcStart   = st_ff.start;
  assign sampleHold = st_ff.hold;
  assign selAddr    = st_ff.selA;
  assign selEnable  = st_ff.selEn;
  assign ampGain    = st_ff.gain;

endmodule : aiss_card_end

// ===== hw/aiss_pkg.sv
// aiss_pkg: constants and types shared by both ends of the scan sequencer
// assumes a 20 MHz clock common to host and card logic
package aiss_pkg;

  // clock and settling times
  localparam int CLK_MHZ        = 20;
  localparam int SETTLE_G1_US   = 15;
  localparam int SETTLE_GMAX_US = 50;
  localparam int SETTLE_EXT_US  = 100;
  localparam int SETTLE_G1_CYC   = SETTLE_G1_US * CLK_MHZ;
  localparam int SETTLE_GMAX_CYC = SETTLE_GMAX_US * CLK_MHZ;
  localparam int SETTLE_EXT_CYC  = SETTLE_EXT_US * CLK_MHZ;
  localparam int CNT_W           = 12;

  // four-location window
  localparam int ADDR_W = 2;
  localparam int DATA_W = 16;
  localparam logic [ADDR_W-1:0] LOC_CTRL = 2'h0;
  localparam logic [ADDR_W-1:0] LOC_CHAN = 2'h1;
  localparam logic [ADDR_W-1:0] LOC_GAIN = 2'h2;
  localparam logic [ADDR_W-1:0] LOC_DATA = 2'h3;

  // control word bits (write) and status bits (read)
  localparam int CB_CONV   = 0;
  localparam int CB_IRQEN  = 1;
  localparam int CB_SCAN   = 2;
  localparam int CB_TRIG   = 3;
  localparam int CB_EXTDLY = 4;
  localparam int SB_DONE   = 5;
  localparam int SB_BUSY   = 6;
  localparam int SB_SETTLE = 7;

  // channels and gains
  localparam int CHAN_W   = 5;
  localparam int N_CHAN   = 32;
  localparam int GAIN_W   = 2;
  localparam int RES_W    = 12;
  localparam logic [GAIN_W-1:0] GAIN_X1 = 2'h0;
  localparam logic [GAIN_W-1:0] GAIN_X8 = 2'h3;

  // result coding selection
  localparam logic [1:0] CODE_TWOS = 2'h2;
  localparam logic [RES_W-1:0] SIGN_FLIP = 12'h800;

  typedef enum logic [1:0] {
    AISS_IDLE = 2'b00,
    AISS_CONV = 2'b01
  } aiss_conv_t;

  typedef enum logic [1:0] {
    AISS_H_IDLE = 2'b00,
    AISS_H_WAIT = 2'b01
  } aiss_host_t;

endpackage : aiss_pkg

// ===== hw/aiss_bus_if.sv
// aiss_bus_if: memory-mapped window between host and card
// assumes both ends share clk; no tri-state, strobes are one-cycle pulses
`timescale 1ns/1ns
interface aiss_bus_if;
  logic [aiss_pkg::ADDR_W-1:0] addr;
  logic [aiss_pkg::DATA_W-1:0] wrData;
  logic                        wrStb;
  logic                        rdStb;
  logic [aiss_pkg::DATA_W-1:0] rdData;
  logic                        rdAck;
  logic                        irq;

  modport dev  (input addr, wrData, wrStb, rdStb,
                output rdData, rdAck, irq);
  modport host (output addr, wrData, wrStb, rdStb,
                input rdData, rdAck, irq);
endinterface : aiss_bus_if

// ===== hw/aiss_host_end.sv
// aiss_host_end: host side master of the four-location window
// assumes user issues commands with valid/ready, one read outstanding
`timescale 1ns/1ns
module aiss_host_end (
  input  wire logic                        clk,
  input  wire logic                        rst,
  aiss_bus_if.host                         bus,
  input  wire logic                        cmdValid,
  input  wire logic                        cmdWrite,
  input  wire logic [aiss_pkg::ADDR_W-1:0] cmdAddr,
  input  wire logic [aiss_pkg::DATA_W-1:0] cmdData,
  output logic                             cmdReady,
  output logic                             rspValid,
  output logic [aiss_pkg::DATA_W-1:0]      rspData,
  output logic                             hostIrq
);

  typedef struct packed {
    aiss_pkg::aiss_host_t        state;
    logic                        ready;
    logic [aiss_pkg::ADDR_W-1:0] addr;
    logic [aiss_pkg::DATA_W-1:0] wd;
    logic                        wr;
    logic                        rd;
    logic                        rv;
    logic [aiss_pkg::DATA_W-1:0] rdat;
    logic                        irq;
  } aiss_hst_t;

  aiss_hst_t st_ff;
  aiss_hst_t nxt_st;

  // command issue and read return
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.wr  = 1'b0;
    nxt_st.rd  = 1'b0;
    nxt_st.rv  = 1'b0;
    nxt_st.irq = bus.irq;
    case (st_ff.state)
      aiss_pkg::AISS_H_IDLE:
      begin
        if (cmdValid && st_ff.ready)
        begin
          nxt_st.addr = cmdAddr;
          nxt_st.wd   = cmdData;
          nxt_st.wr   = cmdWrite;
          nxt_st.rd   = !cmdWrite;
          if (!cmdWrite)
          begin
            nxt_st.ready = 1'b0;
            nxt_st.state = aiss_pkg::AISS_H_WAIT;
          end
        end
      end
      aiss_pkg::AISS_H_WAIT:
      begin
        if (bus.rdAck)
        begin
          nxt_st.rv    = 1'b1;
          nxt_st.rdat  = bus.rdData;
          nxt_st.ready = 1'b1;
          nxt_st.state = aiss_pkg::AISS_H_IDLE;
        end
      end
      default:
      begin
        nxt_st.state = aiss_pkg::AISS_H_IDLE;
        nxt_st.ready = 1'b1;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_ff       <= '0;
      st_ff.ready <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // outputs straight from flops
  assign bus.addr   = st_ff.addr;
  assign bus.wrData = st_ff.wd;
  assign bus.wrStb  = st_ff.wr;
  assign bus.rdStb  = st_ff.rd;
  assign cmdReady   = st_ff.ready;
  assign rspValid   = st_ff.rv;
  assign rspData    = st_ff.rdat;
  assign hostIrq    = st_ff.irq;

endmodule : aiss_host_end

// ===== dv/aiss_bus_monitor.sv
// aiss_bus_monitor: bus-level checks on the host/card window
// assumes the interface signals as plain inputs, one clock, async reset
`timescale 1ns/1ns
module aiss_bus_monitor (
  input wire logic                        clk,
  input wire logic                        rst,
  input wire logic [aiss_pkg::ADDR_W-1:0] addr,
  input wire logic [aiss_pkg::DATA_W-1:0] wrData,
  input wire logic                        wrStb,
  input wire logic                        rdStb,
  input wire logic [aiss_pkg::DATA_W-1:0] rdData,
  input wire logic                        rdAck,
  input wire logic                        irq
);
  logic [3:0]                  enFf;
  logic [aiss_pkg::ADDR_W-1:0] rdLocFf;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // mirror of the four enables and the location of the last read
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      enFf    <= 4'h0;
      rdLocFf <= 2'h0;
    end
    else
    begin
      if (wrStb && addr == aiss_pkg::LOC_CTRL)
      begin
        enFf <= wrData[4:1];
      end
      if (rdStb)
      begin
        rdLocFf <= addr;
      end
    end
  end

  ack_follow_a: assert property (rdStb |=> rdAck)
    else $error("read strobe not answered next cycle");
  ack_cause_a: assert property (rdAck |-> $past(rdStb))
    else $error("read ack without a read strobe");
  ack_pulse_a: assert property (rdAck |=> !rdAck)
    else $error("read ack longer than one cycle");
  result_width_a: assert property (
    rdAck && rdLocFf == aiss_pkg::LOC_DATA |-> rdData[15:12] == 4'h0)
    else $error("result has bits above twelve");
  read_hold_a: assert property (!rdAck |-> $stable(rdData))
    else $error("read data changed without a read");
  enable_echo_a: assert property (
    rdAck && rdLocFf == aiss_pkg::LOC_CTRL |-> rdData[4:1] == $past(enFf))
    else $error("status enables differ from last control write");
  status_irq_a: assert property (
    rdAck && rdLocFf == aiss_pkg::LOC_CTRL
    |-> irq == (rdData[aiss_pkg::SB_DONE] && rdData[aiss_pkg::CB_IRQEN]))
    else $error("interrupt disagrees with done and enable");
  // irq and the enable mirror update on the same edge
  irq_gated_a: assert property (irq |-> enFf[0])
    else $error("interrupt while generation disabled");

  // main scenarios reached
  data_read_c: cover property (rdAck && rdLocFf == aiss_pkg::LOC_DATA);
  irq_seen_c: cover property ($rose(irq));
  chan_read_c: cover property (rdAck && rdLocFf == aiss_pkg::LOC_CHAN);
endmodule : aiss_bus_monitor

// ===== dv/analog_input_scan_sequencer_tb.sv
// analog_input_scan_sequencer_tb: host end facing card end, with checks
// assumes a converter stand-in that answers ten cycles after each start
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected at %0t: got %0h exp %0h", $time, g, e); end end
module analog_input_scan_sequencer_tb;
  localparam int LIMIT = 30000;
  logic        clk, rst, cmdValid, cmdWrite, cmdReady, rspValid, hostIrq;
  logic        extTrig, diffMode, adcDone, adcStart, sampleHold, selEnable;
  logic [1:0]  cmdAddr, codeSel, ampGain;
  logic [15:0] cmdData, rspData, rv;
  logic [11:0] adcData;
  logic [4:0]  selAddr;
  int          err_count, num_checks, cyc, convCnt, breakCnt, b;

  aiss_bus_if bus ();
  aiss_host_end aiss_host_end_inst (.clk(clk), .rst(rst), .bus(bus),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
    .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
    .rspData(rspData), .hostIrq(hostIrq));
  aiss_card_end aiss_card_end_inst (.clk(clk), .rst(rst), .bus(bus),
    .extTrig(extTrig), .diffMode(diffMode), .codeSel(codeSel),
    .adcDone(adcDone), .adcData(adcData), .adcStart(adcStart),
    .sampleHold(sampleHold), .selAddr(selAddr), .selEnable(selEnable),
    .ampGain(ampGain));
  aiss_bus_monitor aiss_bus_monitor_inst (.clk(clk), .rst(rst),
    .addr(bus.addr), .wrData(bus.wrData), .wrStb(bus.wrStb),
    .rdStb(bus.rdStb), .rdData(bus.rdData), .rdAck(bus.rdAck),
    .irq(bus.irq));

  // clock
  always #25 clk = ~clk;

  // cycle count, selector-off count and hang limit
  always @(posedge clk)
  begin
    cyc++;
    if (!selEnable && !rst) breakCnt++;
    if (cyc == LIMIT)
    begin
      err_count++;
      conclude();
    end
  end

  // converter stand-in: done pulse ten cycles after a start
  always @(negedge clk)
  begin
    adcDone <= (convCnt == 1);
    if (convCnt != 0) convCnt <= convCnt - 1;
    else if (adcStart) convCnt <= 10;
  end

  task automatic conclude();
    if (err_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(negedge clk);
    cmdValid = 1'b1; cmdWrite = 1'b1; cmdAddr = a; cmdData = d;
    do @(posedge clk); while (cmdReady !== 1'b1);
    @(negedge clk);
    cmdValid = 1'b0;
    repeat (2) @(negedge clk);
  endtask : wr

  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    int n;
    @(negedge clk);
    cmdValid = 1'b1; cmdWrite = 1'b0; cmdAddr = a;
    do @(posedge clk); while (cmdReady !== 1'b1);
    @(negedge clk);
    cmdValid = 1'b0;
    n = 0;
    while (rspValid !== 1'b1 && n < 10)
    begin
      @(negedge clk);
      n++;
    end
    `CHK(rspValid, 1'b1)
    d = rspData;
  endtask : rd

  // optional channel write, then control write; timed start when ch >= 0
  task automatic conv(input int ch, input logic [1:0] g,
                      input logic [15:0] ctl, input int minC);
    int t0;
    t0 = cyc;
    if (ch >= 0) wr(aiss_pkg::LOC_CHAN, 16'(ch));
    wr(aiss_pkg::LOC_CTRL, ctl);
    while (adcStart !== 1'b1 && cyc - t0 < 2100) @(negedge clk);
    `CHK(sampleHold, 1'b1)
    if (ch >= 0)
    begin
      `CHK((cyc - t0 >= minC) && (cyc - t0 <= minC + 20), 1'b1)
      `CHK(ampGain, g)
    end
    repeat (14) @(negedge clk);
  endtask : conv

  initial
  begin
    clk = 0; rst = 1; cmdValid = 0; cmdWrite = 0; cmdAddr = 0; cmdData = 0;
    extTrig = 0; diffMode = 0; codeSel = 0; adcData = 12'hA5C; adcDone = 0;
    err_count = 0; num_checks = 0; cyc = 0; convCnt = 0; breakCnt = 0;
    repeat (2) @(negedge clk);
    rst = 0;
    rd(aiss_pkg::LOC_CTRL, rv);
    `CHK(rv[4:1], 4'h0)
    // one gain code per channel, then timed conversions
    for (int c = 1; c < 5; c++)
    begin
      wr(aiss_pkg::LOC_CHAN, 16'(c));
      wr(aiss_pkg::LOC_GAIN, 16'(c - 1));
    end
    conv(3, 2'h2, 16'h0001, 300);
    rd(aiss_pkg::LOC_CHAN, rv);
    `CHK(rv[4:0], 5'h03)
    rd(aiss_pkg::LOC_DATA, rv);
    `CHK(rv, 16'h0A5C)
    b = breakCnt;
    conv(4, 2'h3, 16'h0001, 1000);
    `CHK(breakCnt - b, 1)
    wr(aiss_pkg::LOC_CTRL, 16'h0010);
    conv(1, 2'h0, 16'h0011, 2000);
    // drop the extended delay before the next channel change
    wr(aiss_pkg::LOC_CTRL, 16'h0000);
    codeSel = 2'h2;
    conv(2, 2'h1, 16'h0001, 300);
    rd(aiss_pkg::LOC_DATA, rv);
    `CHK(rv, 16'h025C)
    codeSel = 2'h0;
    // scanning: step, wrap, and direct write mixed in
    conv(30, 2'h0, 16'h0005, 300);
    rd(aiss_pkg::LOC_CHAN, rv);
    `CHK(rv[4:0], 5'h1F)
    conv(-1, 2'h0, 16'h0005, 0);
    rd(aiss_pkg::LOC_CHAN, rv);
    `CHK(rv[4:0], 5'h00)
    conv(7, 2'h0, 16'h0005, 300);
    rd(aiss_pkg::LOC_CHAN, rv);
    `CHK(rv[4:0], 5'h08)
    // differential mode wraps the scan at sixteen channels
    diffMode = 1'b1;
    conv(15, 2'h0, 16'h0005, 300);
    rd(aiss_pkg::LOC_CHAN, rv);
    `CHK(rv[4:0], 5'h00)
    diffMode = 1'b0;
    // interrupt on from a cleared done flag, cleared by data read, then off
    rd(aiss_pkg::LOC_DATA, rv);
    `CHK(rv, 16'h0A5C)
    conv(-1, 2'h0, 16'h0007, 0);
    `CHK(hostIrq, 1'b1)
    rd(aiss_pkg::LOC_DATA, rv);
    repeat (3) @(negedge clk);
    `CHK(hostIrq, 1'b0)
    conv(-1, 2'h0, 16'h0001, 0);
    rd(aiss_pkg::LOC_CTRL, rv);
    `CHK(rv[aiss_pkg::SB_DONE], 1'b1)
    `CHK(hostIrq, 1'b0)
    // external trigger start
    wr(aiss_pkg::LOC_CTRL, 16'h0008);
    extTrig = 1'b1;
    @(negedge clk);
    extTrig = 1'b0;
    b = cyc;
    while (adcStart !== 1'b1 && cyc - b < 2100) @(negedge clk);
    `CHK(adcStart, 1'b1)
    repeat (14) @(negedge clk);
    conclude();
  end
endmodule : analog_input_scan_sequencer_tb
